// file: led_prot_pkg.sv
package led_prot_pkg;

    // clock and time base
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MS_PS         = 1000000000;
    localparam int MS_CYCLES     = MS_PS / CLK_PERIOD_PS;

    // times as printed
    localparam int STBY_MS       = 25;
    localparam int HICCUP_MS     = 128;
    localparam int FULL_DUTY_MS  = 5;
    localparam int DEGLITCH_NS   = 20000;
    localparam int DEGLITCH_CYC  = (DEGLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DIM_CYCLES    = 7;
    localparam int START_CYC     = 16;

    // register map (byte addresses, low 12 address bits decoded)
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam int          CTRL_SINK_EN_BIT = 0;
    localparam int          CTRL_CLEAR_BIT   = 1;
    localparam logic        CTRL_SINK_EN_RST = 1'b1;

    // current scale, 9'h100 is nominal
    localparam logic [8:0] LEVEL_FULL  = 9'h100;
    localparam logic [8:0] LEVEL_FLOOR = 9'h080;
    localparam logic [8:0] LEVEL_STEP  = 9'h008;

    typedef enum logic [2:0] {
        ST_OFF   = 3'b000,
        ST_START = 3'b001,
        ST_RUN   = 3'b010,
        ST_PROBE = 3'b011,
        ST_PROT  = 3'b100,
        ST_OTP   = 3'b101,
        ST_STBY  = 3'b110
    } state_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } ahb_in_t;

    typedef struct packed {
        logic dim_in;
        logic supply_ok;
        logic uvlo;
        logic ot_hot;
        logic ot_cool;
        logic fold_hot;
        logic fold_en_cmp;
        logic open_diag_cmp;
        logic open_cmp;
        logic short_cmp;
    } sense_t;

endpackage

// file: led_driver_protection_fsm.sv
// Overview of operation
// R1 - dim low 25ms enters standby
// R2 - dim high leaves standby automatically
// R3 - sink follows dim input level
// R4 - startup when dim high and supply valid
// R5 - supply lockout: output off, fault reported
// R6 - overtemperature shuts sinks, recovery restarts
// R7 - overtemperature drives fault line until removed
// R8 - foldback lowers current to half floor
// R9 - foldback enabled by foldback comparator
// R10 - open persists 7 cycles or 5ms trips
// R11 - recheck every 128ms, reactivate when cleared
// R12 - open fault holds line low until removed
// R13 - comparators deglitched 20us; only open_cmp and short_cmp are deglitched here, the others are used undelayed
// R14 - open protection gated by diagnostic comparator
// R15 - short persists 7 cycles or 5ms trips
// R16 - short fault latched until host release or power cycle
// R17 - fault reporting only while dim active
// R18 - open-drain shared line, low sensed shuts output
// R19 - host release or power cycle clears fault
// R20 - host dims between 200Hz and 1kHz
// R21 - internal timebase, cycles counted on rising dim
// R22 - fault line is OR of all sources
`timescale 1ns/1ps
module led_driver_protection_fsm #(
    parameter int MS_CYC = led_prot_pkg::MS_CYCLES
) (
    input  wire logic                  clock,
    input  wire logic                  nrst,
    input  wire led_prot_pkg::ahb_in_t ahb,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire led_prot_pkg::sense_t  sense,
    input  wire logic                  fault_line_n_i,
    output logic                       fault_line_n_o,
    output logic                       fault_line_n_oe,
    output logic                       sink_on,
    output logic                       fold_active,
    output logic [8:0]                 current_level
);
    import led_prot_pkg::*;

    localparam int PW = $clog2(MS_CYC);
    localparam int DW = $clog2(DEGLITCH_CYC + 1);

    typedef struct packed {
        state_t                st;
        logic [PW-1:0]         pre;
        logic                  tick;
        logic [4:0]            stby_cnt;
        logic                  standby;
        logic [7:0]            hic_cnt;
        logic [3:0]            start_cnt;
        logic [DW-1:0]         probe_cnt;
        logic                  dim_q;
        logic [1:0][DW-1:0]    dg_cnt;
        logic [1:0]            qual;
        logic [1:0]            hit;
        logic [1:0][2:0]       cyc_cnt;
        logic [1:0][2:0]       full_cnt;
        logic                  open_flt;
        logic                  short_lat;
        logic                  otp;
        logic                  sink_on;
        logic                  fold_active;
        logic [8:0]            level;
        logic                  fault_o;
        logic                  fault_oe;
        logic                  sink_en;
        logic                  wr_pend;
        logic [11:0]           wr_addr;
        logic [31:0]           hrdata;
        logic                  hreadyout;
        logic                  hresp;
    } regs_t;

    regs_t r;
    regs_t n;

    logic       dim;
    logic       rise;
    logic       ext_low;
    logic       addr_ph;
    logic       clear_req;
    logic       supply_bad;
    logic [1:0] trip;
    logic [1:0] cmp;
    logic [1:0] en;

    always_comb begin
        n         = r;
        n.tick    = 1'b0;
        dim       = sense.dim_in;
        rise      = dim && !r.dim_q;
        n.dim_q   = dim;
        // a peer pulling the line low; our own pull is not counted as a peer
        ext_low   = !fault_line_n_i && r.fault_oe;
        supply_bad = sense.uvlo || !sense.supply_ok;
        clear_req = 1'b0;
        trip      = 2'b00;

        // millisecond timebase
        if (r.pre == PW'(MS_CYC - 1)) begin // R21
            n.pre  = '0;
            n.tick = 1'b1;
        end else begin
            n.pre = r.pre + PW'(1);
        end

        // standby entry after continuous low, exit on any high
        if (dim) begin
            n.stby_cnt = '0; // R2
            n.standby  = 1'b0; // R2
        end else if (r.tick && r.stby_cnt != 5'(STBY_MS)) begin
            n.stby_cnt = r.stby_cnt + 5'd1;
        end
        if (!dim && n.stby_cnt == 5'(STBY_MS)) begin
            n.standby = 1'b1; // R1
        end

        // per-comparator deglitch and persistence; 0 open, 1 short
        cmp = {sense.short_cmp, sense.open_cmp};
        en  = {1'b1, sense.open_diag_cmp}; // R14
        for (int i = 0; i < 2; i++) begin
            if (r.sink_on && cmp[i] && en[i]) begin
                if (r.dg_cnt[i] != DW'(DEGLITCH_CYC)) begin
                    n.dg_cnt[i] = r.dg_cnt[i] + DW'(1);
                end
            end else begin
                n.dg_cnt[i] = '0;
            end
            // short on-times never reach the count, so they never qualify
            n.qual[i] = (n.dg_cnt[i] == DW'(DEGLITCH_CYC)); // R13
            if (rise) begin
                n.cyc_cnt[i] = r.hit[i] ? r.cyc_cnt[i] + 3'd1 : 3'd0; // R21
                n.hit[i]     = 1'b0;
            end
            if (r.qual[i]) begin
                n.hit[i] = 1'b1;
            end
            if (!r.qual[i]) begin
                n.full_cnt[i] = '0;
            end else if (r.tick) begin
                n.full_cnt[i] = r.full_cnt[i] + 3'd1;
            end
            if (r.st != ST_RUN || !en[i]) begin
                n.cyc_cnt[i]  = '0;
                n.full_cnt[i] = '0;
                n.hit[i]      = 1'b0;
            end
            trip[i] = (r.st == ST_RUN) && !r.standby
                && (n.cyc_cnt[i] == 3'(DIM_CYCLES)
                    || n.full_cnt[i] == 3'(FULL_DUTY_MS)); // R10 R15 R17
        end

        // sequencer
        case (r.st)
            ST_OFF: begin
                if (dim && sense.supply_ok && !sense.uvlo) begin
                    n.st        = ST_START; // R4
                    n.start_cnt = '0;
                end
            end
            ST_START: begin
                n.start_cnt = r.start_cnt + 4'd1;
                if (r.start_cnt == 4'(START_CYC - 1)) begin
                    n.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (trip[0]) begin
                    n.open_flt = 1'b1; // R10
                end
                if (trip[1]) begin
                    n.short_lat = 1'b1; // R16
                end
                if (trip != 2'b00) begin
                    n.st      = ST_PROT;
                    n.hic_cnt = '0;
                end
            end
            ST_PROT: begin
                if (r.tick) begin
                    n.hic_cnt = r.hic_cnt + 8'd1;
                end
                if (r.tick && r.hic_cnt == 8'(HICCUP_MS - 1)) begin
                    n.st        = ST_PROBE; // R11
                    n.probe_cnt = '0;
                end
            end
            ST_PROBE: begin
                // one clean deglitch window of conduction clears the channel
                if (r.qual != 2'b00) begin
                    n.st      = ST_PROT; // R11
                    n.hic_cnt = '0;
                end else if (r.probe_cnt == DW'(DEGLITCH_CYC)) begin
                    n.st       = ST_RUN; // R11
                    n.open_flt = 1'b0; // R12
                end else if (r.sink_on) begin
                    n.probe_cnt = r.probe_cnt + DW'(1);
                end
            end
            ST_OTP: begin
                if (sense.ot_cool && !sense.ot_hot) begin
                    n.st        = ST_START; // R6
                    n.start_cnt = '0;
                    n.otp       = 1'b0; // R7
                end
            end
            ST_STBY: begin
                if (dim) begin
                    n.st = ST_OFF; // R2
                end
            end
            default: begin
                n.st = ST_OFF;
            end
        endcase

        // overriding conditions, strongest first
        if (supply_bad) begin
            n.st  = ST_OFF; // R5
            n.otp = 1'b0;
        end else if (sense.ot_hot && !n.standby) begin
            n.st  = ST_OTP; // R6
            n.otp = 1'b1; // R7
        end else if (n.standby) begin
            n.st = ST_STBY; // R1
        end

        // bus: zero wait states, always OKAY
        n.hreadyout = 1'b1;
        n.hresp     = 1'b0;
        addr_ph     = ahb.hsel && ahb.htrans[1] && ahb.hready;
        if (r.wr_pend && ahb.hready && r.wr_addr == REG_CTRL) begin
            n.sink_en = ahb.hwdata[CTRL_SINK_EN_BIT];
            clear_req = ahb.hwdata[CTRL_CLEAR_BIT];
        end
        if (ahb.hready) begin
            n.wr_pend = addr_ph && ahb.hwrite;
            n.wr_addr = ahb.haddr[11:0];
        end
        if (addr_ph && !ahb.hwrite) begin
            case (ahb.haddr[11:0])
                REG_CTRL:   n.hrdata = {31'h0, r.sink_en};
                REG_STATUS: n.hrdata = {20'h0, !fault_line_n_i, !r.fault_oe, sense.uvlo,
                                        r.otp, r.short_lat, r.open_flt, r.standby,
                                        r.fold_active, r.sink_on, r.st};
                default:    n.hrdata = 32'h0;
            endcase
        end

        // host release of the latched short and open faults; a fresh short trip this cycle wins
        if (clear_req && !(r.st == ST_RUN && trip[1])) begin
            n.short_lat = 1'b0; // R19
            n.open_flt  = 1'b0; // R19
        end

        // sink gating
        n.sink_on = (n.st == ST_RUN || n.st == ST_PROBE) && dim && r.sink_en
            && !ext_low; // R3 R18

        // foldback ramps one step per millisecond
        n.fold_active = sense.fold_en_cmp && sense.fold_hot; // R9
        if (r.tick) begin
            if (r.fold_active && r.level > LEVEL_FLOOR) begin
                n.level = r.level - LEVEL_STEP; // R8
            end else if (!r.fold_active && r.level < LEVEL_FULL) begin
                n.level = r.level + LEVEL_STEP;
            end
        end

        // open drain: level always low, enable low while pulling
        n.fault_o  = 1'b0;
        n.fault_oe = !(!n.standby
            && (supply_bad || n.otp || n.open_flt || n.short_lat)); // R5 R7 R12 R16 R17 R22
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            r           <= '0;
            r.st        <= ST_OFF;
            r.level     <= LEVEL_FULL;
            r.fault_oe  <= 1'b1;
            r.sink_en   <= CTRL_SINK_EN_RST;
            r.hreadyout <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign hrdata          = r.hrdata;
    assign hreadyout       = r.hreadyout;
    assign hresp           = r.hresp;
    assign fault_line_n_o  = r.fault_o;
    assign fault_line_n_oe = r.fault_oe;
    assign sink_on         = r.sink_on;
    assign fold_active     = r.fold_active;
    assign current_level   = r.level;

endmodule

// file: led_prot_sva.sv
`timescale 1ns/1ps
module led_prot_sva #(
    parameter int MS_CYC = 50
) (
    input wire logic                  clock,
    input wire logic                  nrst,
    input wire led_prot_pkg::ahb_in_t ahb,
    input wire logic [31:0]           hrdata,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire led_prot_pkg::sense_t  sense,
    input wire logic                  fault_line_n_i,
    input wire logic                  fault_line_n_o,
    input wire logic                  fault_line_n_oe,
    input wire logic                  sink_on,
    input wire logic                  fold_active,
    input wire logic [8:0]            current_level
);
    import led_prot_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_hot; sense.ot_hot && sense.dim_in; endsequence
    sequence s_low; (sense.uvlo || !sense.supply_ok) && sense.dim_in; endsequence
    sequence s_far; ahb.hsel && ahb.htrans[1] && ahb.hready && !ahb.hwrite
        && ahb.haddr[11:0] > 12'h007; endsequence
    property p_dim_off; !sense.dim_in |=> !sink_on; endproperty
    a_dim_off: assert property (p_dim_off) else $error("sink on, dim low");
    property p_uv_off; s_low |-> ##2 !sink_on; endproperty
    a_uv_off: assert property (p_uv_off) else $error("sink on, supply low");
    property p_uv_flt; s_low |-> ##[1:3] !fault_line_n_oe; endproperty
    a_uv_flt: assert property (p_uv_flt) else $error("supply low unreported");
    property p_ot_off; sense.ot_hot |-> ##2 !sink_on; endproperty
    a_ot_off: assert property (p_ot_off) else $error("sink on while hot");
    property p_ot_flt; s_hot |-> ##[1:3] !fault_line_n_oe; endproperty
    a_ot_flt: assert property (p_ot_flt) else $error("overheat unreported");
    property p_peer; !fault_line_n_i && fault_line_n_oe |=> !sink_on; endproperty
    a_peer: assert property (p_peer) else $error("sink on, line low");
    property p_fold_on; sense.fold_en_cmp && sense.fold_hot |=> fold_active; endproperty
    a_fold_on: assert property (p_fold_on) else $error("foldback idle");
    property p_fold_off; !sense.fold_en_cmp |=> !fold_active; endproperty
    a_fold_off: assert property (p_fold_off) else $error("foldback active");
    property p_floor; current_level >= LEVEL_FLOOR && current_level <= LEVEL_FULL; endproperty
    a_floor: assert property (p_floor) else $error("level out of range");
    property p_step; $changed(current_level) |->
        (current_level - $past(current_level)) inside {9'h008, 9'h1f8}; endproperty
    a_step: assert property (p_step) else $error("level step wrong");
    property p_od; fault_line_n_o == 1'b0 && hreadyout && !hresp; endproperty
    a_od: assert property (p_od) else $error("drive or bus reply wrong");
    property p_far; s_far |=> hrdata == 32'h0; endproperty
    a_far: assert property (p_far) else $error("unmapped read nonzero");
endmodule

// file: peer_line_model.sv
`timescale 1ns/1ps
module peer_line_model (
    input  wire logic clock,
    input  wire logic dut_oe,
    input  wire logic pull,
    output logic      line
);
    // neighbour reacts a cycle late, as a slow peer would
    logic pull_r = 1'b0;
    always_ff @(posedge clock) begin
        pull_r <= pull;
    end
    // pull-up wins only when nobody pulls
    assign line = dut_oe & ~pull_r;
endmodule

// file: led_driver_protection_fsm_bench.sv
`timescale 1ns/1ps
module led_driver_protection_fsm_bench;
    import led_prot_pkg::*;
    localparam int MS = 50;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        rd_pend = 1'b0;
    logic        peer = 1'b0;
    logic        d;
    sense_t      sense = '0;
    sense_t      sv = '0;
    ahb_in_t     ahb;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, line, fo, oe, sink_on, fold_active;
    logic [8:0]  current_level;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int          fail_count = 0;
    int          checked = 0;
    assign ahb = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata, hreadyout};
    led_driver_protection_fsm #(.MS_CYC(MS)) dut_u (.clock(clock), .nrst(nrst),
        .ahb(ahb), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sense(sense), .fault_line_n_i(line), .fault_line_n_o(fo),
        .fault_line_n_oe(oe), .sink_on(sink_on), .fold_active(fold_active),
        .current_level(current_level));
    peer_line_model peer_u (.clock(clock), .dut_oe(oe), .pull(peer), .line(line));
    initial begin
        forever #2.5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] v);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel    <= 1'b0;
        htrans  <= 2'b00;
        hwdata  <= v;
        rd_pend <= !wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd_pend <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic at(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic put();
        @(posedge clock);
        sense <= sv;
    endtask
    // read data is judged where it lands, against the oldest note
    always @(posedge clock) begin
        if (rd_pend && hreadyout === 1'b1) begin
            chk(hrdata & msk_q.pop_front(), exp_q.pop_front());
        end
    end
    initial begin
        #300000;
        fail_count++;
        give_verdict();
    end
    initial begin
        sv.supply_ok = 1'b1;
        sv.ot_cool = 1'b1;
        sense = sv;
        void'($urandom(32'h912b));
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        at(1);
        chk(sink_on, 0);
        chk(current_level, LEVEL_FULL);
        chk(oe, 1);
        rd(REG_CTRL, 32'hffffffff, 32'h1);
        bus(1'b1, 12'h010, $urandom);
        rd(12'h010, 32'hffffffff, 32'h0);
        sv.dim_in = 1'b1;
        put();
        at(START_CYC + 3);
        chk(sink_on, 1);
        repeat (16) begin
            d = 1'($urandom);
            sv.dim_in = d;
            put();
            at(1);
            chk(sink_on, d);
        end
        // host pwm at a quarter kilohertz, inside the recommended band
        repeat (3) begin
            sv.dim_in = 1'b1;
            put();
            at(2 * MS);
            chk(sink_on, 1);
            sv.dim_in = 1'b0;
            put();
            at(2 * MS);
            chk(sink_on, 0);
        end
        sv.dim_in = 1'b1;
        put();
        @(posedge clock) peer <= 1'b1;
        at(3);
        chk(sink_on, 0);
        @(posedge clock) peer <= 1'b0;
        at(3);
        chk(sink_on, 1);
        sv.fold_en_cmp = 1'b1;
        sv.fold_hot = 1'b1;
        put();
        at(2);
        chk(fold_active, 1);
        at(20 * MS);
        chk(current_level, LEVEL_FLOOR);
        sv.fold_en_cmp = 1'b0;
        put();
        at(2);
        chk(fold_active, 0);
        at(20 * MS);
        chk(current_level, LEVEL_FULL);
        // heat, lockout and lost supply each stop the sink and pull the line low
        for (int i = 0; i < 4; i++) begin
            sv.ot_hot = (i == 0);
            sv.ot_cool = (i != 0);
            sv.uvlo = (i == 1);
            sv.supply_ok = (i != 2);
            put();
            at(START_CYC + 4);
            chk(sink_on, i == 3);
            chk(oe, i == 3);
        end
        sv.short_cmp = 1'b1;
        put();
        at(3990);
        chk(oe, 1);
        at(5 * MS + 40);
        chk(sink_on, 0);
        chk(oe, 0);
        sv.short_cmp = 1'b0;
        put();
        at(128 * MS + 4100);
        chk(sink_on, 1);
        chk(oe, 0);
        rd(REG_STATUS, 32'h80, 32'h80);
        bus(1'b1, REG_CTRL, 32'h3);
        at(3);
        chk(oe, 1);
        sv.open_cmp = 1'b1;
        put();
        at(4400);
        chk(oe, 1);
        sv.open_diag_cmp = 1'b1;
        put();
        at(4400);
        chk(sink_on, 0);
        chk(oe, 0);
        sv.open_cmp = 1'b0;
        put();
        at(128 * MS + 4100);
        chk(sink_on, 1);
        chk(oe, 1);
        sv.dim_in = 1'b0;
        put();
        at(23 * MS);
        rd(REG_STATUS, 32'h20, 32'h0);
        at(2 * MS + 10);
        rd(REG_STATUS, 32'h20, 32'h20);
        sv.dim_in = 1'b1;
        put();
        at(START_CYC + 4);
        chk(sink_on, 1);
        rd(REG_STATUS, 32'h20, 32'h0);
        at(2);
        give_verdict();
    end
endmodule
bind led_driver_protection_fsm led_prot_sva #(.MS_CYC(MS_CYC)) chk_u (.clock(clock),
    .nrst(nrst), .ahb(ahb), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sense(sense), .fault_line_n_i(fault_line_n_i), .fault_line_n_o(fault_line_n_o),
    .fault_line_n_oe(fault_line_n_oe), .sink_on(sink_on), .fold_active(fold_active),
    .current_level(current_level));
